/* core/rsq_pkg.sv */
package rsq_pkg;

	// ==========================================================
	// register map (byte addresses, one word each)
	localparam logic [7:0] ADDR_CAUSE   = 8'h00;
	localparam logic [7:0] ADDR_WDT_RLD = 8'h04;
	localparam logic [7:0] ADDR_WDT_FD  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;
	localparam logic [7:0] ADDR_WDT_CNT = 8'h14;

	// ==========================================================
	// field layout of the cause register
	localparam int CAUSE_W      = 3;
	localparam int OUT_EN_BIT   = 7;

	// ==========================================================
	// reset values and keys
	localparam logic [15:0] WDT_RLD_RST  = 16'hffff;
	localparam logic [7:0]  WDT_FEED_KEY = 8'ha5;
	localparam logic        OUT_EN_RST   = 1'b0;

	// ==========================================================
	// timing counts in system clocks
	localparam logic [7:0]  PULSE_LAST   = 8'hff;
	localparam logic [7:0]  WDT_PRE_LAST = 8'hff;
	localparam int          PWRUP_MAX    = 258;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic wdt;
		logic sw;
		logic ext;
	} rsq_cause_t;

	localparam rsq_cause_t CAUSE_EXT = 3'h1;
	localparam rsq_cause_t CAUSE_SW  = 3'h2;
	localparam rsq_cause_t CAUSE_WDT = 3'h4;
	localparam rsq_cause_t CAUSE_NONE = 3'h0;

	typedef struct packed {
		logic drv;
		logic lvl;
	} rsq_pin_t;

	typedef enum logic [1:0] {
		PST_IDLE  = 2'b01,
		PST_PULSE = 2'b10
	} rsq_pst_t;

endpackage

/* core/rsq_pulse.sv */
`timescale 1ns/1ps
module rsq_pulse (
	// clock and reset
	input  wire logic       mclk_in,
	input  wire logic       rstn_in,
	// control
	input  wire logic       start_in,
	// status
	output logic            active_out,
	output logic [7:0]      count_out
);

	rsq_pkg::rsq_pst_t state;
	rsq_pkg::rsq_pst_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			rsq_pkg::PST_IDLE: begin
				if (start_in) begin
					next_state = rsq_pkg::PST_PULSE;
				end
			end
			rsq_pkg::PST_PULSE: begin
				if (count_out == rsq_pkg::PULSE_LAST) begin
					next_state = rsq_pkg::PST_IDLE;
				end
			end
			default: begin
				next_state = rsq_pkg::PST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= rsq_pkg::PST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// retrigger during a pulse is ignored, length stays fixed
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count_out <= 8'h00;
		end else if (state == rsq_pkg::PST_PULSE) begin
			count_out <= count_out + 8'h01;
		end else begin
			count_out <= 8'h00;
		end
	end

	assign active_out = (state == rsq_pkg::PST_PULSE);

endmodule

/* core/rsq_core.sv */
`timescale 1ns/1ps
// Summary of operation
// (R1) external reset pin resets the system
// (R2) internal reset drives indicator pin low
// (R3) indicator pulse lasts exactly 256 clocks
// (R4) external reset never makes a pulse
// (R5) cause bit 7 enables the indicator
// (R6) cause register shows last reset source
// (R7) watchdog runs from reset onward
// (R8) watchdog timeout makes internal reset, pulse
// (R9) power-up low hold at most 258 clocks
// (R10) tied-back pin records every reset external
// (R11) pin released outside an enabled pulse
module rsq_core (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// reset sources
	input  wire logic        external_reset_input_n_in,
	input  wire logic        sw_reset_in,
	// system reset and interrupt
	output logic             sys_rstn_out,
	output logic             irq_out,
	// shared port/timer pin, port role drive
	input  wire logic        port_lvl_in,
	input  wire logic        port_oe_in,
	output logic             shared_port_timer_reset_pin_out,
	output logic             shared_port_timer_reset_pin_oe_out
);

	// ==========================================================
	// external reset synchroniser
	logic ext_meta_n;
	logic ext_sync_n;
	logic ext_low;
	logic ext_low_q;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ext_meta_n <= 1'b0;
			ext_sync_n <= 1'b0;
		end else begin
			ext_meta_n <= external_reset_input_n_in;
			ext_sync_n <= ext_meta_n;
		end
	end

	assign ext_low = !ext_sync_n;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// same level as the sync reset, so no false edge
			ext_low_q <= 1'b1;
		end else begin
			ext_low_q <= ext_low;
		end
	end

	// ==========================================================
	// registers
	logic             out_en;
	logic             pulse_en;
	rsq_pkg::rsq_cause_t cause;
	rsq_pkg::rsq_cause_t irq_st;
	rsq_pkg::rsq_cause_t irq_msk;
	rsq_pkg::rsq_cause_t evt;
	logic [15:0]      wdt_rld;
	logic [15:0]      wdt_cnt;
	logic [7:0]       wdt_pre;
	logic             wdt_tick;
	logic             wdt_to;
	logic             int_evt;
	logic             pulse_active;
	logic [7:0]       pulse_cnt;
	logic             sys_rst;
	logic             wr_en;
	logic             feed;

	function automatic logic hit(input logic [7:0] a);
		hit = (paddr_in == a);
	endfunction

	assign wr_en = psel_in && penable_in && pwrite_in;
	assign feed  = wr_en && hit(rsq_pkg::ADDR_WDT_FD) &&
		(pwdata_in[7:0] == rsq_pkg::WDT_FEED_KEY);
	assign sys_rst = !sys_rstn_out;

	// (R5) indicator enable bit
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			out_en <= rsq_pkg::OUT_EN_RST;
		end else if (wr_en && hit(rsq_pkg::ADDR_CAUSE)) begin
			out_en <= pwdata_in[rsq_pkg::OUT_EN_BIT];
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wdt_rld <= rsq_pkg::WDT_RLD_RST;
		end else if (wr_en && hit(rsq_pkg::ADDR_WDT_RLD)) begin
			wdt_rld <= pwdata_in[15:0];
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_msk <= rsq_pkg::CAUSE_NONE;
		end else if (wr_en && hit(rsq_pkg::ADDR_IRQ_MSK)) begin
			irq_msk <= pwdata_in[rsq_pkg::CAUSE_W-1:0];
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_st <= rsq_pkg::CAUSE_NONE;
		end else if (wr_en && hit(rsq_pkg::ADDR_IRQ_ST)) begin
			irq_st <= (irq_st & ~pwdata_in[rsq_pkg::CAUSE_W-1:0]) | evt;
		end else begin
			irq_st <= irq_st | evt;
		end
	end

	assign irq_out = |(irq_st & irq_msk);

	// ==========================================================
	// watchdog
	// (R7) prescaler and counter run from reset on
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wdt_pre <= 8'h00;
		end else begin
			wdt_pre <= wdt_pre + 8'h01;
		end
	end

	assign wdt_tick = (wdt_pre == rsq_pkg::WDT_PRE_LAST);
	// (R8) expiry raises an internal reset
	assign wdt_to = wdt_tick && (wdt_cnt == 16'h0000) && !sys_rst;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wdt_cnt <= rsq_pkg::WDT_RLD_RST;
		end else if (sys_rst || feed || wdt_to) begin
			wdt_cnt <= wdt_rld;
		end else if (wdt_tick) begin
			wdt_cnt <= wdt_cnt - 16'h0001;
		end
	end

	// ==========================================================
	// internal reset pulse
	// (R4) only watchdog and instruction start a pulse
	assign int_evt = (wdt_to || (sw_reset_in && !sys_rst)) && !pulse_active;

	rsq_pulse u_pulse (
		.mclk_in    (mclk_in),
		.rstn_in    (rstn_in),
		.start_in   (int_evt),
		.active_out (pulse_active),
		.count_out  (pulse_cnt)
	);

	// enable captured at the trigger, the cpu is held during the pulse
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pulse_en <= 1'b0;
		end else if (int_evt) begin
			pulse_en <= out_en;
		end
	end

	// (R1) external pin or internal pulse hold the system
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sys_rstn_out <= 1'b0;
		end else begin
			sys_rstn_out <= !(ext_low || int_evt || pulse_active);
		end
	end

	// ==========================================================
	// reset cause
	assign evt.ext = ext_low && !ext_low_q;
	assign evt.wdt = wdt_to;
	assign evt.sw  = sw_reset_in && !sys_rst && !wdt_to && !pulse_active;

	// (R6) one-hot record of the latest source
	// (R10) external assertion overrides, so a tie-back reads external
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cause <= rsq_pkg::CAUSE_EXT;
		end else if (ext_low) begin
			cause <= rsq_pkg::CAUSE_EXT;
		end else if (evt.wdt) begin
			cause <= rsq_pkg::CAUSE_WDT;
		end else if (evt.sw) begin
			cause <= rsq_pkg::CAUSE_SW;
		end
	end

	// ==========================================================
	// shared pin
	rsq_pkg::rsq_pin_t pin;
	logic drive_low;

	// (R2) enabled pulse pulls the pin low
	// (R9) no power-up hold, the pin is released from reset
	assign drive_low = pulse_active && pulse_en;

	// (R11) otherwise the port or timer role owns the pin
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin <= 2'b00;
		end else if (int_evt && out_en) begin
			pin <= 2'b10;
		end else if (drive_low && (pulse_cnt != rsq_pkg::PULSE_LAST)) begin
			pin <= 2'b10;
		end else begin
			pin <= {port_oe_in, port_lvl_in};
		end
	end

	assign shared_port_timer_reset_pin_out    = pin.lvl;
	assign shared_port_timer_reset_pin_oe_out = pin.drv;

	// ==========================================================
	// apb read path, zero wait states
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			prdata_out <= 32'h0000_0000;
			case (paddr_in)
				rsq_pkg::ADDR_CAUSE: begin
					prdata_out[rsq_pkg::OUT_EN_BIT] <= out_en;
					prdata_out[rsq_pkg::CAUSE_W-1:0] <= cause;
				end
				rsq_pkg::ADDR_WDT_RLD: prdata_out[15:0] <= wdt_rld;
				rsq_pkg::ADDR_IRQ_ST:  prdata_out[2:0] <= irq_st;
				rsq_pkg::ADDR_IRQ_MSK: prdata_out[2:0] <= irq_msk;
				rsq_pkg::ADDR_WDT_CNT: prdata_out[15:0] <= wdt_cnt;
				default: prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == rsq_pkg::ADDR_CAUSE) || (a == rsq_pkg::ADDR_WDT_RLD) ||
			(a == rsq_pkg::ADDR_WDT_FD) || (a == rsq_pkg::ADDR_IRQ_ST) ||
			(a == rsq_pkg::ADDR_IRQ_MSK) || (a == rsq_pkg::ADDR_WDT_CNT);
	endfunction

	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in && penable_in && !mapped(paddr_in);

	// ==========================================================
	// checks
	// (R1) synchronised external reset holds the system
	AST_EXT_RESETS: assert property ( // (R1)
		@(posedge mclk_in) disable iff (!rstn_in)
		ext_low |=> !sys_rstn_out)
		else $error("external reset did not reset the system");

	// (R2) enabled internal reset drives pin low next cycle
	AST_PIN_LOW: assert property ( // (R2)
		@(posedge mclk_in) disable iff (!rstn_in)
		int_evt && out_en |=> (pin.drv && !pin.lvl) [*8])
		else $error("indicator pin not driven low");

	// (R3) pulse ends after exactly 256 counts
	AST_PULSE_LEN: assert property ( // (R3)
		@(posedge mclk_in) disable iff (!rstn_in)
		$fell(pulse_active) |-> $past(pulse_cnt) == rsq_pkg::PULSE_LAST)
		else $error("pulse length wrong");

	// (R4) external reset alone never starts a pulse
	AST_EXT_NO_PULSE: assert property ( // (R4)
		@(posedge mclk_in) disable iff (!rstn_in)
		!pulse_active && !wdt_to && !(sw_reset_in && !sys_rst)
		|=> !pulse_active)
		else $error("pulse without internal reset");

	// (R5) disabled indicator never pulls low
	AST_EN_GATE: assert property ( // (R5)
		@(posedge mclk_in) disable iff (!rstn_in)
		int_evt && !out_en |=> !(pin.drv && !pin.lvl) || $past(port_oe_in))
		else $error("disabled indicator drove pin");

	// (R6) cause is always one-hot
	AST_CAUSE_ONEHOT: assert property ( // (R6)
		@(posedge mclk_in) disable iff (!rstn_in)
		$onehot(cause))
		else $error("cause not one-hot");

	// (R7) watchdog counts down on each tick
	AST_WDT_RUNS: assert property ( // (R7)
		@(posedge mclk_in) disable iff (!rstn_in)
		wdt_tick && !sys_rst && !feed && wdt_cnt != 16'h0000
		|=> wdt_cnt == $past(wdt_cnt) - 16'h0001)
		else $error("watchdog not counting");

	// (R8) timeout starts a pulse and records cause
	AST_WDT_RESET: assert property ( // (R8)
		@(posedge mclk_in) disable iff (!rstn_in)
		wdt_to && !ext_low |=> pulse_active && cause == rsq_pkg::CAUSE_WDT)
		else $error("timeout without reset");

	// (R10) external assertion records external cause
	AST_TIEBACK: assert property ( // (R10)
		@(posedge mclk_in) disable iff (!rstn_in)
		ext_low |=> cause == rsq_pkg::CAUSE_EXT)
		else $error("external reset not recorded");

	// (R11) outside a pulse the port owns the pin
	AST_RELEASE: assert property ( // (R11)
		@(posedge mclk_in) disable iff (!rstn_in)
		!pulse_active && !int_evt |=> pin == $past({port_oe_in, port_lvl_in}))
		else $error("pin not released");

	COV_WDT: cover property (@(posedge mclk_in) disable iff (!rstn_in)
		wdt_to && out_en);
	COV_SW: cover property (@(posedge mclk_in) disable iff (!rstn_in)
		evt.sw && out_en);
	COV_EXT: cover property (@(posedge mclk_in) disable iff (!rstn_in)
		evt.ext);

endmodule

/* test/rsq_sys_model.sv */
`timescale 1ns/1ps
module rsq_sys_model (
	// shared pin as driven by the device
	input  wire logic pin_lvl_in,
	input  wire logic pin_oe_in,
	// board controls
	input  wire logic ext_req_in,
	input  wire logic tie_back_in,
	// board nets
	output logic      pin_wire_out,
	output logic      external_reset_input_n_out
);
	// ==========================================================
	// board wiring
	// released pin is pulled up on the board
	assign pin_wire_out = pin_oe_in ? pin_lvl_in : 1'b1;
	// reset input source
	// tie-back replaces the push button, never mixed with it
	assign external_reset_input_n_out = tie_back_in ? pin_wire_out
		: !ext_req_in;
endmodule

/* test/rsq_core_test.sv */
`timescale 1ns/1ps
module rsq_core_test;
	logic        mclk_in;
	logic        rstn_in;
	logic        psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err;
	logic        sw_rst, sys_rstn, irq;
	logic        port_lvl, port_oe, pin_lvl, pin_oe;
	logic        ext_req, tie, pin_wire, ext_n;
	int          n_errors, tests_run, n;

	// ==========================================================
	// clock and instances
	always #20 mclk_in = ~mclk_in;

	rsq_core rsq_core_i (
		.mclk_in(mclk_in), .rstn_in(rstn_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.external_reset_input_n_in(ext_n), .sw_reset_in(sw_rst),
		.sys_rstn_out(sys_rstn), .irq_out(irq),
		.port_lvl_in(port_lvl), .port_oe_in(port_oe),
		.shared_port_timer_reset_pin_out(pin_lvl),
		.shared_port_timer_reset_pin_oe_out(pin_oe));

	rsq_sys_model rsq_sys_model_i (
		.pin_lvl_in(pin_lvl), .pin_oe_in(pin_oe), .ext_req_in(ext_req),
		.tie_back_in(tie), .pin_wire_out(pin_wire),
		.external_reset_input_n_out(ext_n));

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		if (n_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge mclk_in);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge mclk_in);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_errors++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_up;
		int i;
		for (i = 0; i < 600; i++) begin
			@(posedge mclk_in);
			if (sys_rstn === 1'b1) break;
		end
		if (i == 600) begin
			n_errors++;
			stop_test();
		end
	endtask

	task automatic sw_kick;
		@(posedge mclk_in);
		sw_rst <= 1'b1;
		@(posedge mclk_in);
		sw_rst <= 1'b0;
	endtask

	// low cycles on the pin; gives up after idle quiet cycles
	task automatic pulse_len(input int idle, output int len);
		len = 0;
		for (int i = 0; i < idle + 300; i++) begin
			@(posedge mclk_in);
			if (pin_oe === 1'b1 && pin_lvl === 1'b0) len++;
			else if (len > 0 || i >= idle) break;
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset;
		apb(1'b0, rsq_pkg::ADDR_CAUSE, 32'h0);
		chk(rd, {24'h0, rsq_pkg::OUT_EN_RST, 4'h0, rsq_pkg::CAUSE_EXT});
		apb(1'b0, rsq_pkg::ADDR_WDT_RLD, 32'h0);
		chk(rd, {16'h0, rsq_pkg::WDT_RLD_RST});
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk({31'h0, pin_oe}, 32'h0);
		port_oe  <= 1'b1;
		port_lvl <= 1'b0;
		repeat (2) @(posedge mclk_in);
		chk({30'h0, pin_oe, pin_lvl}, 32'h2);
		port_oe  <= 1'b0;
		port_lvl <= 1'b1;
		repeat (2) @(posedge mclk_in);
	endtask

	task automatic t_sw(input logic en);
		apb(1'b1, rsq_pkg::ADDR_CAUSE, {24'h0, en, 7'h0});
		apb(1'b1, rsq_pkg::ADDR_IRQ_MSK, 32'h0);
		apb(1'b1, rsq_pkg::ADDR_IRQ_ST, 32'h7);
		sw_kick();
		pulse_len(4, n);
		chk(n, en ? 32'd256 : 32'd0);
		wait_up();
		apb(1'b0, rsq_pkg::ADDR_CAUSE, 32'h0);
		chk({29'h0, rd[2:0]}, {29'h0, rsq_pkg::CAUSE_SW});
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, rsq_pkg::ADDR_IRQ_MSK, 32'h2);
		// the write lands at the access edge, look one edge later
		@(posedge mclk_in);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, rsq_pkg::ADDR_IRQ_ST, 32'h2);
		@(posedge mclk_in);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_ext;
		int drv, low;
		drv = 0;
		low = 0;
		apb(1'b1, rsq_pkg::ADDR_CAUSE, 32'h80);
		@(posedge mclk_in);
		ext_req <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			@(posedge mclk_in);
			if (pin_oe !== 1'b0) drv++;
			if (sys_rstn === 1'b0) low = 1;
		end
		ext_req <= 1'b0;
		wait_up();
		chk(drv, 32'd0);
		chk(low, 32'd1);
		apb(1'b0, rsq_pkg::ADDR_CAUSE, 32'h0);
		chk({29'h0, rd[2:0]}, {29'h0, rsq_pkg::CAUSE_EXT});
	endtask

	task automatic t_tie;
		tie <= 1'b1;
		apb(1'b1, rsq_pkg::ADDR_CAUSE, 32'h80);
		sw_kick();
		repeat (4) @(posedge mclk_in);
		wait_up();
		apb(1'b0, rsq_pkg::ADDR_CAUSE, 32'h0);
		chk({29'h0, rd[2:0]}, {29'h0, rsq_pkg::CAUSE_EXT});
		tie <= 1'b0;
	endtask

	// shortest reload so the timeout lands within one prescale tick
	task automatic t_wdt;
		apb(1'b1, rsq_pkg::ADDR_CAUSE, 32'h80);
		apb(1'b1, rsq_pkg::ADDR_WDT_RLD, 32'h0);
		apb(1'b1, rsq_pkg::ADDR_WDT_FD, {24'h0, rsq_pkg::WDT_FEED_KEY});
		pulse_len(1000, n);
		chk(n, 32'd256);
		wait_up();
		apb(1'b0, rsq_pkg::ADDR_CAUSE, 32'h0);
		chk({29'h0, rd[2:0]}, {29'h0, rsq_pkg::CAUSE_WDT});
		apb(1'b1, rsq_pkg::ADDR_WDT_RLD, {16'h0, rsq_pkg::WDT_RLD_RST});
		apb(1'b1, rsq_pkg::ADDR_WDT_FD, {24'h0, rsq_pkg::WDT_FEED_KEY});
	endtask

	// ==========================================================
	// main sequence
	initial begin
		mclk_in   = 1'b0;
		rstn_in   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		sw_rst    = 1'b0;
		port_lvl  = 1'b1;
		port_oe   = 1'b0;
		ext_req   = 1'b0;
		tie       = 1'b0;
		n_errors  = 0;
		tests_run = 0;
		repeat (8) @(posedge mclk_in);
		rstn_in <= 1'b1;
		wait_up();
		t_reset();
		t_sw(1'b1);
		t_sw(1'b0);
		t_ext();
		t_tie();
		t_wdt();
		stop_test();
	end
endmodule
